// >>> vpic_controller.v
// Vectored priority interrupt controller: flags, arbitration and presentation.
//
// How it works
// R1: Arbitrate events here, then present winner to CPU.
// R2: Sixty-four request sources, IRQ 0 to 63.
// R3: Sources map onto 44 vectors, sharing allowed.
// R4: Single-vector and multi-vector delivery modes.
// R5: Five external inputs, each with edge select.
// R6: Three-bit group priority, higher wins.
// R7: Two-bit subpriority breaks group priority ties.
// R8: Software flag set acts like hardware event.
// R9: Vector address built from software table base.
// R10: Vector address uses software-set entry spacing.
// R11: No shadow register set ever presented.
// R12: Full ties resolved by lowest IRQ number.
// R13: IRQ n flag/enable at bit n of word.
// R14: Word k holds vectors 4k to 4k+3.
// R15: Capture error and event pairs share vectors.
// R16: Serial port fault, receive, transmit share vector.
// R17: Two-wire and change-notice groups share vectors.
// R18: Parallel port event and error share 35.
// R19: External inputs are IRQs 3,8,13,18,23, non-persistent.
// R20: Transfer channels IRQs 60-63 use vectors 40-43.
// R21: Sources classed persistent or non-persistent.
// R22: Mode bit one selects multi-vector, resets zero.
// R23: Proximity code zero off, p delays priority <=p.
// R24: Edge bit one rising, zero falling, reset zero.
// R25: Status reports last presented vector and level.
// R26: Eligible needs flag, enable, nonzero group priority.
// R27: Persistent flag re-sets while condition remains.
`include "vpic_map.vh"

module vpic_controller #(
	parameter NIRQ = `VPIC_IRQ_COUNT, // R2
	parameter NEXT = `VPIC_EXT_COUNT,
	parameter NWORDS = `VPIC_PRIO_WORDS,
	parameter SPACEW = 10
) (
	input wire sys_clk,
	input wire rst_n,
	input wire [NIRQ-1:0] periphReq,
	input wire [NEXT-1:0] extPin,
	input wire [NIRQ-1:0] swFlagSet,
	input wire [NIRQ-1:0] swFlagClr,
	input wire [31:0] requestEnablesLow,
	input wire [31:0] requestEnablesHigh,
	input wire multiVectorSelect,
	input wire [2:0] proximityThreshold,
	input wire [NEXT-1:0] extEdgeSelect,
	input wire [31:0] vectorTableBase,
	input wire [SPACEW-1:0] vectorSpacing,
	input wire [15:0] proxReload,
	input wire prioWrEn,
	input wire [3:0] prioWrIndex,
	input wire [31:0] prioWrData,
	input wire [3:0] prioRdIndex,
	output wire [31:0] prioRdData,
	output wire [31:0] requestFlagsLow,
	output wire [31:0] requestFlagsHigh,
	output reg cpuRequest_r,
	output reg [5:0] cpuVector_r,
	output reg [2:0] cpuLevel_r,
	output reg [31:0] cpuVectorAddr_r,
	output reg cpuShadowSet_r,
	output reg [5:0] presentedVector_r,
	output reg [2:0] presentedLevel_r,
	output reg proxRunning_r
);

	// ----------------------------------------
	// Proximity timer states
	// ----------------------------------------
	localparam [1:0] PX_IDLE = 2'b00;
	localparam [1:0] PX_COUNT = 2'b01;
	localparam [1:0] PX_RELEASE = 2'b10;

	// ----------------------------------------
	// Functions
	// ----------------------------------------
	// Maps an IRQ number onto its vector number.
	function [5:0] irqToVector;
		input [5:0] irq;
		begin
			if (irq <= 6'd5) begin
				irqToVector = irq;
			end else if (irq == 6'd6) begin
				irqToVector = 6'd5;
			end else if (irq <= 6'd10) begin
				irqToVector = irq - 6'd1;
			end else if (irq == 6'd11) begin
				irqToVector = 6'd9;
			end else if (irq <= 6'd15) begin
				irqToVector = irq - 6'd2;
			end else if (irq == 6'd16) begin
				irqToVector = 6'd13;
			end else if (irq <= 6'd20) begin
				irqToVector = irq - 6'd3;
			end else if (irq == 6'd21) begin
				irqToVector = 6'd17;
			end else if (irq <= 6'd25) begin
				irqToVector = irq - 6'd4;
			end else if (irq == 6'd26) begin
				irqToVector = 6'd21;
			end else if (irq <= 6'd36) begin
				irqToVector = irq - 6'd5;
			end else if (irq <= 6'd38) begin
				irqToVector = 6'd31;
			end else if (irq <= 6'd41) begin
				irqToVector = 6'd32;
			end else if (irq <= 6'd44) begin
				irqToVector = 6'd33;
			end else if (irq <= 6'd47) begin
				irqToVector = 6'd34;
			end else if (irq <= 6'd49) begin
				irqToVector = 6'd35;
			end else if (irq <= 6'd52) begin
				irqToVector = 6'd36;
			end else if (irq <= 6'd55) begin
				irqToVector = 6'd37;
			end else if (irq <= 6'd58) begin
				irqToVector = 6'd38;
			end else begin
				irqToVector = irq - 6'd20;
			end
		end
	endfunction

	// Returns the IRQ number of external input e.
	function [5:0] extIrq;
		input [2:0] e;
		begin
			case (e)
				3'd0: extIrq = `VPIC_EXT_IRQ0;
				3'd1: extIrq = `VPIC_EXT_IRQ1;
				3'd2: extIrq = `VPIC_EXT_IRQ2;
				3'd3: extIrq = `VPIC_EXT_IRQ3;
				default: extIrq = `VPIC_EXT_IRQ4;
			endcase
		end
	endfunction

	// ----------------------------------------
	// Priority word storage
	// ----------------------------------------
	wire [NWORDS*32-1:0] prioWords;

	vpic_prio_mem #(
		.WORDS(NWORDS),
		.IDXW(4)
	) uPrioMem (
		.sys_clk(sys_clk),
		.rst_n(rst_n),
		.wrEn(prioWrEn),
		.wrIndex(prioWrIndex),
		.wrData(prioWrData),
		.rdIndex(prioRdIndex),
		.rdData_r(prioRdData),
		.allWords(prioWords)
	);

	// ----------------------------------------
	// External input synchronisers and edge detection
	// ----------------------------------------
	reg [NEXT-1:0] extSync1_r;
	reg [NEXT-1:0] extSync2_r;
	reg [NEXT-1:0] extSync3_r;
	reg [NEXT-1:0] extStable_r;
	reg [NEXT-1:0] extEdge;
	reg [NEXT-1:0] extStable_nxt;
	integer e;

	always @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			extSync1_r <= {NEXT{1'b0}};
			extSync2_r <= {NEXT{1'b0}};
			extSync3_r <= {NEXT{1'b0}};
			extStable_r <= {NEXT{1'b0}};
		end else begin
			extSync1_r <= extPin;
			extSync2_r <= extSync1_r;
			extSync3_r <= extSync2_r;
			extStable_r <= extStable_nxt;
		end
	end

	// A level change counts once the second and third stages agree.
	always @* begin
		extStable_nxt = extStable_r;
		extEdge = {NEXT{1'b0}};
		for (e = 0; e < NEXT; e = e + 1) begin
			if (extSync2_r[e] == extSync3_r[e] && extSync3_r[e] != extStable_r[e]) begin
				extStable_nxt[e] = extSync3_r[e];
				extEdge[e] = (extSync3_r[e] == extEdgeSelect[e]); // R24 R5
			end
		end
	end

	// ----------------------------------------
	// Request flags
	// ----------------------------------------
	reg [NIRQ-1:0] flags_r;
	reg [NIRQ-1:0] flags_nxt;
	reg [NIRQ-1:0] periphPrev_r;
	reg [NIRQ-1:0] hwEvent;
	wire [NIRQ-1:0] persistMask;
	wire [NIRQ-1:0] extMask;
	integer i;

	assign persistMask = `VPIC_PERSIST_MASK; // R21
	assign extMask = `VPIC_EXT_IRQ_MASK; // R19

	always @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			periphPrev_r <= `VPIC_FLAGS_RST;
			flags_r <= `VPIC_FLAGS_RST;
		end else begin
			periphPrev_r <= periphReq;
			flags_r <= flags_nxt;
		end
	end

	// Persistent sources follow the level, other peripheral requests fire on a rising edge, external inputs on their selected edge.
	always @* begin
		hwEvent = (persistMask & periphReq) // R27 R21
			| (~persistMask & ~extMask & periphReq & ~periphPrev_r);
		for (i = 0; i < NEXT; i = i + 1) begin
			hwEvent[extIrq(i[2:0])] = extEdge[i]; // R19
		end
		// A set in the cycle of a clear wins.
		flags_nxt = (flags_r & ~swFlagClr) | hwEvent | swFlagSet; // R8
	end

	assign requestFlagsLow = flags_r[31:0]; // R13
	assign requestFlagsHigh = flags_r[63:32]; // R13

	// ----------------------------------------
	// Arbitration
	// ----------------------------------------
	wire [NIRQ-1:0] enables;
	reg [5:0] bestIrq;
	reg [5:0] bestVec;
	reg [2:0] bestGp;
	reg [1:0] bestSp;
	reg found;
	reg [5:0] curVec;
	reg [2:0] curGp;
	reg [1:0] curSp;
	integer n;

	assign enables = {requestEnablesHigh, requestEnablesLow}; // R13

	// Scans from IRQ 63 down so that equal keys leave the lowest IRQ winning.
	always @* begin
		bestIrq = 6'h00;
		bestVec = 6'h00;
		bestGp = 3'h0;
		bestSp = 2'h0;
		found = 1'b0;
		curVec = 6'h00;
		curGp = 3'h0;
		curSp = 2'h0;
		for (n = NIRQ - 1; n >= 0; n = n - 1) begin
			curVec = irqToVector(n[5:0]); // R3 R15 R16 R17 R18 R20
			curGp = prioWords[curVec*`VPIC_SLOT_BITS + `VPIC_GP_LSB +: `VPIC_GP_W]; // R14
			curSp = prioWords[curVec*`VPIC_SLOT_BITS + `VPIC_SP_LSB +: `VPIC_SP_W]; // R14
			if (flags_r[n] && enables[n] && curGp != 3'h0) begin // R26
				if (!found || {curGp, curSp} >= {bestGp, bestSp}) begin // R6 R7 R12
					found = 1'b1;
					bestIrq = n[5:0];
					bestVec = curVec;
					bestGp = curGp;
					bestSp = curSp;
				end
			end
		end
	end

	// ----------------------------------------
	// Proximity timer
	// ----------------------------------------
	reg [1:0] pxState_r;
	reg [1:0] pxState_nxt;
	reg [15:0] pxCount_r;
	reg [15:0] pxCount_nxt;
	reg delayable;
	reg present;

	always @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			pxState_r <= PX_IDLE;
			pxCount_r <= `VPIC_PROX_RST;
		end else begin
			pxState_r <= pxState_nxt;
			pxCount_r <= pxCount_nxt;
		end
	end

	// Low-priority winners wait out the timer; higher ones pass at once.
	always @* begin
		delayable = (proximityThreshold != `VPIC_PROX_OFF) // R23
			&& (bestGp <= proximityThreshold);
		pxState_nxt = pxState_r;
		pxCount_nxt = pxCount_r;
		present = 1'b0;
		case (pxState_r)
			PX_IDLE: begin
				if (found && !delayable) begin
					present = 1'b1;
				end else if (found && delayable) begin
					if (proxReload == 16'h0000) begin
						present = 1'b1;
						pxState_nxt = PX_RELEASE;
					end else begin
						pxCount_nxt = proxReload; // R23
						pxState_nxt = PX_COUNT;
					end
				end
			end
			PX_COUNT: begin
				if (!found) begin
					pxState_nxt = PX_IDLE;
				end else if (!delayable) begin
					present = 1'b1;
					pxState_nxt = PX_IDLE;
				end else if (pxCount_r == 16'h0001) begin
					present = 1'b1;
					pxState_nxt = PX_RELEASE;
				end else begin
					pxCount_nxt = pxCount_r - 16'h0001;
				end
			end
			PX_RELEASE: begin
				present = found;
				if (!found) begin
					pxState_nxt = PX_IDLE;
				end
			end
			default: begin
				pxState_nxt = PX_IDLE;
			end
		endcase
	end

	// ----------------------------------------
	// Presentation to the processor
	// ----------------------------------------
	reg [5:0] addrVec;
	reg [15:0] offset;

	always @* begin
		addrVec = multiVectorSelect ? bestVec : 6'h00; // R4 R22
		offset = addrVec * vectorSpacing; // R10
	end

	always @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			cpuRequest_r <= 1'b0;
			cpuVector_r <= `VPIC_VEC_RST;
			cpuLevel_r <= `VPIC_LVL_RST;
			cpuVectorAddr_r <= `VPIC_ADDR_RST;
			cpuShadowSet_r <= 1'b0;
			presentedVector_r <= `VPIC_VEC_RST;
			presentedLevel_r <= `VPIC_LVL_RST;
			proxRunning_r <= 1'b0;
		end else begin
			cpuRequest_r <= present; // R1
			cpuShadowSet_r <= 1'b0; // R11
			proxRunning_r <= (pxState_nxt == PX_COUNT);
			if (present) begin
				cpuVector_r <= bestVec; // R4
				cpuLevel_r <= bestGp;
				cpuVectorAddr_r <= vectorTableBase + {16'h0000, offset}; // R9 R10
				presentedVector_r <= bestVec; // R25
				presentedLevel_r <= bestGp; // R25
			end
		end
	end

endmodule

// >>> vpic_controller_bench.sv
// Self-checking testbench of the interrupt controller.
module vpic_controller_bench;
	timeunit 1ns;
	timeprecision 1ns;
	localparam logic [31:0] BASE = 32'h00001000;
	logic sys_clk = 1'b0;
	logic rst_n = 1'b0;
	logic [63:0] periphReq = 64'h0;
	logic [63:0] swFlagSet = 64'h0;
	logic [63:0] swFlagClr = 64'h0;
	logic [4:0] extPin = 5'h00;
	logic [4:0] extEdgeSelect = 5'h00;
	logic [31:0] requestEnablesLow = 32'hFFFFFFFF;
	logic [31:0] requestEnablesHigh = 32'hFFFFFFFF;
	logic multiVectorSelect = 1'b1;
	logic [2:0] proximityThreshold = 3'h0;
	logic [31:0] vectorTableBase = BASE;
	logic [9:0] vectorSpacing = 10'h020;
	logic [15:0] proxReload = 16'h000A;
	logic prioWrEn = 1'b0;
	logic [3:0] prioWrIndex = 4'h0;
	logic [31:0] prioWrData = 32'h0;
	logic [3:0] prioRdIndex = 4'h0;
	logic [31:0] prioRdData, requestFlagsLow, requestFlagsHigh, cpuVectorAddr_r, seenAddr;
	logic cpuRequest_r, cpuShadowSet_r, proxRunning_r, shadowUsed;
	logic [5:0] cpuVector_r, presentedVector_r, seenVector;
	logic [2:0] cpuLevel_r, presentedLevel_r;
	wire [63:0] flags = {requestFlagsHigh, requestFlagsLow};
	int errors = 0;
	int checked = 0;
	int cycles = 0;
	int irqTab[20] = '{0, 3, 6, 11, 16, 21, 23, 26, 28, 38, 41, 44, 47, 49, 52, 55, 58, 59, 60, 63};
	int vecTab[20] = '{0, 3, 5, 9, 13, 17, 19, 21, 23, 31, 32, 33, 34, 35, 36, 37, 38, 39, 40, 43};
	int extTab[5] = '{3, 8, 13, 18, 23};
	vpic_controller DUT (.sys_clk, .rst_n, .periphReq, .extPin, .swFlagSet, .swFlagClr,
		.requestEnablesLow, .requestEnablesHigh, .multiVectorSelect, .proximityThreshold,
		.extEdgeSelect, .vectorTableBase, .vectorSpacing, .proxReload, .prioWrEn, .prioWrIndex,
		.prioWrData, .prioRdIndex, .prioRdData, .requestFlagsLow, .requestFlagsHigh,
		.cpuRequest_r, .cpuVector_r, .cpuLevel_r, .cpuVectorAddr_r, .cpuShadowSet_r,
		.presentedVector_r, .presentedLevel_r, .proxRunning_r);
	vpic_cpu_model cpu (.sys_clk, .cpuRequest_r, .cpuVector_r, .cpuVectorAddr_r,
		.cpuShadowSet_r, .seenVector, .seenAddr, .shadowUsed);
	initial begin
		forever #25 sys_clk = ~sys_clk;
	end
	// ----------------------------------------
	// Access tasks
	// ----------------------------------------
	task automatic check(input string what, input logic [63:0] seen, input logic [63:0] exp);
		checked++;
		if (seen !== exp) begin
			errors++;
			$display("CHECK FAILED %s expected %0h seen %0h", what, exp, seen);
		end
	endtask
	task automatic test_done();
		if (errors == 0 && checked > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask
	task automatic pulse(input logic [63:0] m, input logic clr);
		@(posedge sys_clk);
		if (clr) swFlagClr <= m;
		else swFlagSet <= m;
		@(posedge sys_clk);
		swFlagSet <= 64'h0;
		swFlagClr <= 64'h0;
	endtask
	task automatic wrPrio(input logic [3:0] k, input logic [31:0] d);
		@(posedge sys_clk);
		prioWrEn <= 1'b1;
		prioWrIndex <= k;
		prioWrData <= d;
		@(posedge sys_clk);
		prioWrEn <= 1'b0;
	endtask
	task automatic rdPrio(input logic [3:0] k, input logic [31:0] exp);
		@(posedge sys_clk);
		prioRdIndex <= k;
		@(posedge sys_clk);
		@(negedge sys_clk);
		check("priority word", 64'(prioRdData), 64'(exp));
	endtask
	task automatic waitReq();
		int n;
		n = 0;
		@(negedge sys_clk);
		while (cpuRequest_r !== 1'b1 && n < 20) begin
			@(negedge sys_clk);
			n++;
		end
		check("request", 64'(cpuRequest_r), 64'h1);
		@(negedge sys_clk);
	endtask
	always @(posedge sys_clk) begin
		cycles++;
		if (cycles == 6000) begin
			errors++;
			test_done();
		end
	end
	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	initial begin
		int k;
		int n;
		logic ran;
		repeat (12) @(posedge sys_clk);
		rst_n <= 1'b1;
		@(negedge sys_clk);
		check("flags", flags, 64'h0);
		check("status", 64'({presentedLevel_r, presentedVector_r, cpuRequest_r}), 64'h0);
		for (k = 0; k < 11; k++) wrPrio(4'(k), 32'h04040404);
		rdPrio(4'h1, 32'h04040404);
		rdPrio(4'hB, 32'h0);
		for (k = 0; k < 20; k++) begin
			pulse(64'h1 << irqTab[k], 1'b0);
			waitReq();
			check("vector", 64'(seenVector), 64'(vecTab[k]));
			check("address", 64'(seenAddr), 64'(BASE + vecTab[k] * 32));
			pulse(64'h1 << irqTab[k], 1'b1);
			repeat (3) @(negedge sys_clk);
		end
		@(posedge sys_clk);
		multiVectorSelect <= 1'b0;
		pulse(64'h40, 1'b0);
		waitReq();
		check("single address", 64'(seenAddr), 64'(BASE));
		check("status vector", 64'(presentedVector_r), 64'h5);
		pulse(64'h40, 1'b1);
		multiVectorSelect <= 1'b1;
		pulse(64'h410, 1'b0);
		waitReq();
		check("natural order", 64'(cpuVector_r), 64'h4);
		wrPrio(4'h2, 32'h04040604);
		repeat (3) @(negedge sys_clk);
		check("subpriority", 64'(cpuVector_r), 64'h9);
		wrPrio(4'h1, 32'h04040408);
		repeat (3) @(negedge sys_clk);
		check("group priority", 64'({cpuLevel_r, cpuVector_r}), 64'h84);
		@(posedge sys_clk);
		requestEnablesLow <= 32'hFFFFFFEF;
		wrPrio(4'h2, 32'h04040004);
		repeat (3) @(negedge sys_clk);
		check("ineligible", 64'(cpuRequest_r), 64'h0);
		pulse(64'h410, 1'b1);
		requestEnablesLow <= 32'hFFFFFFFF;
		wrPrio(4'h1, 32'h04040404);
		wrPrio(4'h2, 32'h04040404);
		periphReq <= 64'h1 << 37;
		repeat (3) @(negedge sys_clk);
		pulse(64'h1 << 37, 1'b1);
		@(negedge sys_clk);
		check("persistent", 64'(flags[37]), 64'h1);
		@(posedge sys_clk);
		periphReq <= 64'h10;
		repeat (3) @(negedge sys_clk);
		pulse(64'h2000000010, 1'b1);
		repeat (2) @(negedge sys_clk);
		check("edge source", flags, 64'h0);
		for (k = 0; k < 5; k++) begin
			@(posedge sys_clk);
			periphReq <= 64'h0;
			extEdgeSelect <= 5'(1 << k);
			extPin <= 5'(1 << k);
			repeat (8) @(negedge sys_clk);
			check("rising pin", 64'(flags[extTab[k]]), 64'h1);
			pulse(64'h1 << extTab[k], 1'b1);
			extPin <= 5'h00;
			repeat (8) @(negedge sys_clk);
			check("wrong edge", 64'(flags[extTab[k]]), 64'h0);
		end
		@(posedge sys_clk);
		extEdgeSelect <= 5'h00;
		extPin <= 5'h10;
		repeat (8) @(negedge sys_clk);
		@(posedge sys_clk);
		extPin <= 5'h00;
		repeat (8) @(negedge sys_clk);
		check("falling pin", 64'(flags[23]), 64'h1);
		pulse(64'h1 << 23, 1'b1);
		proximityThreshold <= 3'h2;
		pulse(64'h10, 1'b0);
		n = 0;
		ran = 1'b0;
		while (cpuRequest_r !== 1'b1 && n < 40) begin
			@(negedge sys_clk);
			if (proxRunning_r === 1'b1) ran = 1'b1;
			if (flags[4] === 1'b1) n++;
		end
		check("proximity delay", 64'(n), 64'd12);
		check("proximity timer", 64'(ran), 64'h1);
		pulse(64'h10, 1'b1);
		proxReload <= 16'h0000;
		pulse(64'h10, 1'b0);
		repeat (2) @(negedge sys_clk);
		check("zero reload", 64'(cpuRequest_r), 64'h1);
		pulse(64'h10, 1'b1);
		proximityThreshold <= 3'h0;
		repeat (3) @(negedge sys_clk);
		check("shadow set", 64'(shadowUsed), 64'h0);
		test_done();
	end
endmodule

// >>> vpic_controller_properties.sv
// Concurrent checks on the controller ports.
`include "vpic_map.vh"
module vpic_controller_properties #(
	parameter NIRQ = 64,
	parameter SPACEW = 10
) (
	input logic sys_clk,
	input logic rst_n,
	input logic [NIRQ-1:0] periphReq,
	input logic [NIRQ-1:0] swFlagSet,
	input logic [NIRQ-1:0] swFlagClr,
	input logic [31:0] requestEnablesLow,
	input logic [31:0] requestEnablesHigh,
	input logic multiVectorSelect,
	input logic [2:0] proximityThreshold,
	input logic [31:0] vectorTableBase,
	input logic [SPACEW-1:0] vectorSpacing,
	input logic [31:0] requestFlagsLow,
	input logic [31:0] requestFlagsHigh,
	input logic cpuRequest_r,
	input logic [5:0] cpuVector_r,
	input logic [2:0] cpuLevel_r,
	input logic [31:0] cpuVectorAddr_r,
	input logic cpuShadowSet_r,
	input logic [5:0] presentedVector_r,
	input logic [2:0] presentedLevel_r,
	input logic proxRunning_r
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!rst_n);
	wire [63:0] flags = {requestFlagsHigh, requestFlagsLow};
	wire [63:0] live = flags & {requestEnablesHigh, requestEnablesLow};
	wire [63:0] held = periphReq & `VPIC_PERSIST_MASK;
	wire [63:0] clrOnly = swFlagClr & ~swFlagSet & ~periphReq & ~`VPIC_EXT_IRQ_MASK;
	shadow_never_a: assert property (!cpuShadowSet_r)
		else $error("shadow set presented");
	soft_set_a: assert property ((flags & $past(swFlagSet)) == $past(swFlagSet))
		else $error("software set lost");
	soft_clear_a: assert property ((flags & $past(clrOnly)) == 64'h0)
		else $error("software clear ignored");
	persist_reset_a: assert property ((flags & $past(held)) == $past(held))
		else $error("persistent flag dropped");
	request_eligible_a: assert property (cpuRequest_r |-> $past(live) != 64'h0)
		else $error("request without eligible source");
	request_drop_a: assert property (live == 64'h0 |=> !cpuRequest_r)
		else $error("request stays without source");
	vector_range_a: assert property (cpuRequest_r |-> cpuVector_r < 6'h2C && cpuLevel_r != 3'h0)
		else $error("bad vector or level");
	status_match_a: assert property (cpuRequest_r |->
		presentedVector_r == cpuVector_r && presentedLevel_r == cpuLevel_r)
		else $error("status differs from presentation");
	vector_addr_a: assert property ($rose(cpuRequest_r) |-> cpuVectorAddr_r == ($past(multiVectorSelect)
		? $past(vectorTableBase) + 32'(cpuVector_r) * 32'($past(vectorSpacing))
		: $past(vectorTableBase)))
		else $error("vector address wrong");
	prox_off_a: assert property (proximityThreshold == 3'h0 [*2] |-> !proxRunning_r)
		else $error("proximity timer runs while off");
endmodule
bind vpic_controller vpic_controller_properties #(.NIRQ(NIRQ), .SPACEW(SPACEW)) props (
	.sys_clk, .rst_n, .periphReq, .swFlagSet, .swFlagClr, .requestEnablesLow,
	.requestEnablesHigh, .multiVectorSelect, .proximityThreshold, .vectorTableBase,
	.vectorSpacing, .requestFlagsLow, .requestFlagsHigh, .cpuRequest_r, .cpuVector_r,
	.cpuLevel_r, .cpuVectorAddr_r, .cpuShadowSet_r, .presentedVector_r,
	.presentedLevel_r, .proxRunning_r);

// >>> vpic_cpu_model.sv
// Processor core model that takes the interrupts the controller presents.
module vpic_cpu_model (
	input logic sys_clk,
	input logic cpuRequest_r,
	input logic [5:0] cpuVector_r,
	input logic [31:0] cpuVectorAddr_r,
	input logic cpuShadowSet_r,
	output logic [5:0] seenVector,
	output logic [31:0] seenAddr,
	output logic shadowUsed
);
	timeunit 1ns;
	timeprecision 1ns;
	logic reqPrev = 1'b0;
	logic [5:0] vecSeen = 6'h00;
	logic [31:0] addrSeen = 32'h00000000;
	logic shadowSeen = 1'b0;
	assign seenVector = vecSeen;
	assign seenAddr = addrSeen;
	assign shadowUsed = shadowSeen;
	// The core takes a new request when the request line rises.
	always @(posedge sys_clk) begin
		reqPrev <= cpuRequest_r;
		if (cpuRequest_r === 1'b1 && reqPrev !== 1'b1) begin
			vecSeen <= cpuVector_r;
			addrSeen <= cpuVectorAddr_r;
		end
		if (cpuShadowSet_r === 1'b1) begin
			shadowSeen <= 1'b1;
		end
	end
endmodule

// >>> vpic_map.vh
// Constants of the vectored priority interrupt controller.
`ifndef VPIC_MAP_VH
`define VPIC_MAP_VH

// ----------------------------------------
// Sizes
// ----------------------------------------
`define VPIC_IRQ_COUNT 64
`define VPIC_VEC_COUNT 44
`define VPIC_PRIO_WORDS 11
`define VPIC_EXT_COUNT 5

// ----------------------------------------
// Field positions inside a priority control word slot
// ----------------------------------------
`define VPIC_SLOT_BITS 8
`define VPIC_GP_LSB 2
`define VPIC_GP_W 3
`define VPIC_SP_LSB 0
`define VPIC_SP_W 2

// ----------------------------------------
// Source classes
// ----------------------------------------
`define VPIC_PERSIST_MASK 64'h0FFFFFF8_16318C60
`define VPIC_EXT_IRQ_MASK 64'h00000000_00842108
`define VPIC_EXT_IRQ0 6'h03
`define VPIC_EXT_IRQ1 6'h08
`define VPIC_EXT_IRQ2 6'h0D
`define VPIC_EXT_IRQ3 6'h12
`define VPIC_EXT_IRQ4 6'h17

// ----------------------------------------
// Reset values
// ----------------------------------------
`define VPIC_FLAGS_RST 64'h0000000000000000
`define VPIC_EDGE_RST 5'h00
`define VPIC_PRIO_RST 32'h00000000
`define VPIC_PROX_RST 16'h0000
`define VPIC_VEC_RST 6'h00
`define VPIC_LVL_RST 3'h0
`define VPIC_ADDR_RST 32'h00000000

// ----------------------------------------
// Proximity control codes
// ----------------------------------------
`define VPIC_PROX_OFF 3'h0

`endif

// >>> vpic_prio_mem.v
// Priority control word storage with a registered read port.
`include "vpic_map.vh"

module vpic_prio_mem #(
	parameter WORDS = `VPIC_PRIO_WORDS,
	parameter IDXW = 4
) (
	input wire sys_clk,
	input wire rst_n,
	input wire wrEn,
	input wire [IDXW-1:0] wrIndex,
	input wire [31:0] wrData,
	input wire [IDXW-1:0] rdIndex,
	output reg [31:0] rdData_r,
	output wire [WORDS*32-1:0] allWords
);

	reg [31:0] mem_r [0:WORDS-1];

	genvar g;
	generate
		for (g = 0; g < WORDS; g = g + 1) begin : gWord
			always @(posedge sys_clk or negedge rst_n) begin
				if (!rst_n) begin
					mem_r[g] <= `VPIC_PRIO_RST;
				end else if (wrEn && wrIndex == g) begin
					mem_r[g] <= wrData;
				end
			end
			assign allWords[g*32 +: 32] = mem_r[g];
		end
	endgenerate

	// Out-of-range reads return zero.
	always @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			rdData_r <= `VPIC_PRIO_RST;
		end else if (rdIndex < WORDS) begin
			rdData_r <= mem_r[rdIndex];
		end else begin
			rdData_r <= `VPIC_PRIO_RST;
		end
	end

endmodule
